// ---- pkg/dscd_defines.svh ----
`ifndef DSCD_DEFINES_SVH
`define DSCD_DEFINES_SVH

// Operation field codes, bits 15:10 of the operation word.
`define DSCD_OP_NOP      6'h00
`define DSCD_OP_ADREG    6'h02
`define DSCD_OP_RESUME   6'h03
`define DSCD_OP_MEM      6'h06
`define DSCD_OP_BLOCK    6'h07
`define DSCD_OP_CTRL     6'h0A
`define DSCD_OP_DBG      6'h0B

// Field positions inside the operation word.
`define DSCD_F_OP_HI     15
`define DSCD_F_OP_LO     10
`define DSCD_F_DIR       8
`define DSCD_F_SZ_HI     7
`define DSCD_F_SZ_LO     6
`define DSCD_F_REG_HI    3

// Operand size encodings.
`define DSCD_SZ_BYTE     2'h0
`define DSCD_SZ_WORD     2'h1
`define DSCD_SZ_LONG     2'h2
`define DSCD_SZ_RSVD     2'h3

// Packet length and device responses (status bit above 16 data bits).
`define DSCD_PKT_BITS    17
`define DSCD_RSP_OK      17'h0_FFFF
`define DSCD_RSP_NOTRDY  17'h1_0000
`define DSCD_RSP_BUSERR  17'h1_0001
`define DSCD_RSP_ILLEGAL 17'h1_FFFF

// Debug module registers and event bits.
`define DSCD_DBG_STATUS  4'h0
`define DSCD_DBG_MASK    4'h1
`define DSCD_EV_ILLEGAL  0
`define DSCD_EV_BUSERR   1
`define DSCD_EV_RESUME   2
`define DSCD_EV_W        3

// Serial clock made by the host end.
`define DSCD_CLK_PERIOD_NS  100
`define DSCD_SCLK_PERIOD_NS 1600
`define DSCD_SCLK_HALF_CYC  (`DSCD_SCLK_PERIOD_NS / (2 * `DSCD_CLK_PERIOD_NS))

`endif

// ---- pkg/dscd_pkg.sv ----
package dscd_pkg;

    typedef enum logic [2:0] {ST_CMD, ST_EXT, ST_BUSY, ST_DONE, ST_LAST} dscd_state_e;
    typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH} dscd_hstate_e;
    typedef enum logic [0:0] {RS_AD_REG, RS_CTRL_REG} dscd_space_e;

    typedef struct packed {
        logic [2:0]  clk_sync;
        logic [2:0]  din_sync;
        logic        sclk_lvl;
        logic        din_lvl;
        logic [4:0]  bit_cnt;
        logic [15:0] rx_sh;
        logic [16:0] tx_sh;
        dscd_state_e st;
        logic [15:0] cmd;
        logic [2:0]  ext_cnt;
        logic [2:0]  dat_cnt;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] res;
        logic [16:0] fin;
        logic        two;
        logic        blk_rd_ok;
        logic        blk_wr_ok;
        logic [31:0] blk_addr;
        logic        mem_req;
        logic        reg_req;
        logic        resume;
        logic [2:0]  status;
        logic [2:0]  mask;
    } dscd_dev_s;

    typedef struct packed {
        dscd_hstate_e st;
        logic [2:0]   dout_sync;
        logic         dout_lvl;
        logic [7:0]   div;
        logic [4:0]   bit_cnt;
        logic [16:0]  sh;
        logic [16:0]  rx;
        logic         sclk;
        logic         din;
        logic         rx_valid;
    } dscd_host_s;

endpackage

// ---- pkg/dscd_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface dscd_link_if;
    logic debug_serial_clk;
    logic debug_serial_in;
    logic debug_serial_out;

    modport dev (
        input  debug_serial_clk,
        input  debug_serial_in,
        output debug_serial_out
    );
    modport host (
        output debug_serial_clk,
        output debug_serial_in,
        input  debug_serial_out
    );
endinterface
`default_nettype wire

// ---- rtl/dscd_device.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dscd_defines.svh"
module dscd_device (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    // Serial link
    dscd_link_if.dev                   link,
    // Core status and control
    input  wire logic                  halted_i,
    output logic                       resume_o,
    // Core register access
    output logic                       reg_req_o,
    output logic                       reg_we_o,
    output dscd_pkg::dscd_space_e      reg_space_o,
    output logic [15:0]                reg_num_o,
    output logic [31:0]                reg_wdata_o,
    input  wire logic [31:0]           reg_rdata_i,
    input  wire logic                  reg_ack_i,
    // Memory bus cycle stealing
    output logic                       mem_req_o,
    output logic                       mem_we_o,
    output logic [1:0]                 mem_size_o,
    output logic [31:0]                mem_addr_o,
    output logic [31:0]                mem_wdata_o,
    input  wire logic [31:0]           mem_rdata_i,
    input  wire logic                  mem_ack_i,
    input  wire logic                  mem_err_i,
    // Interrupt
    output logic                       irq_o
);
    import dscd_pkg::*;

    dscd_dev_s s;
    dscd_dev_s n;

    logic [15:0] w;
    logic [5:0]  op;
    logic        dir;
    logic [1:0]  sz;
    logic        go;
    logic        rise;
    logic        ill;
    logic [31:0] a;
    logic [31:0] step;

    always_comb begin
        n = s;
        go = 1'b0;
        ill = 1'b0;
        a = 32'h0000_0000;
        step = 32'h0000_0000;
        n.resume = 1'b0;
        n.clk_sync = {s.clk_sync[1:0], link.debug_serial_clk};
        n.din_sync = {s.din_sync[1:0], link.debug_serial_in};
        if (s.clk_sync[2] == s.clk_sync[1]) begin
            n.sclk_lvl = s.clk_sync[2];
        end
        if (s.din_sync[2] == s.din_sync[1]) begin
            n.din_lvl = s.din_sync[2];
        end
        rise = (s.clk_sync[2] == s.clk_sync[1]) && s.clk_sync[2] && !s.sclk_lvl;
        // The top received bit is the host's status bit; it is dropped here.
        w = {s.rx_sh[14:0], n.din_lvl};
        op = w[`DSCD_F_OP_HI:`DSCD_F_OP_LO];
        dir = w[`DSCD_F_DIR];
        sz = w[`DSCD_F_SZ_HI:`DSCD_F_SZ_LO];
        if (rise) begin
            n.rx_sh = w;
            n.tx_sh = {s.tx_sh[15:0], 1'b0};
            n.bit_cnt = s.bit_cnt + 5'd1;
            if (s.bit_cnt == 5'(`DSCD_PKT_BITS - 1)) begin
                n.bit_cnt = 5'd0;
                n.tx_sh = `DSCD_RSP_NOTRDY;
                case (s.st)
                    ST_CMD: begin
                        n.cmd = w;
                        n.addr = 32'h0000_0000;
                        n.data = 32'h0000_0000;
                        n.ext_cnt = 3'd0;
                        n.dat_cnt = 3'd0;
                        if (op != `DSCD_OP_NOP) begin
                            n.blk_rd_ok = 1'b0;
                            n.blk_wr_ok = 1'b0;
                        end
                        case (op)
                            `DSCD_OP_NOP: begin
                                n.blk_rd_ok = s.blk_rd_ok;
                                n.blk_wr_ok = s.blk_wr_ok;
                            end
                            `DSCD_OP_RESUME: n.resume = 1'b1;
                            `DSCD_OP_ADREG, `DSCD_OP_DBG: begin
                                n.addr = {28'h000_0000, w[`DSCD_F_REG_HI:0]};
                                n.ext_cnt = dir ? 3'd0 : 3'd2;
                                n.dat_cnt = n.ext_cnt;
                            end
                            `DSCD_OP_CTRL: begin
                                n.ext_cnt = dir ? 3'd2 : 3'd4;
                                n.dat_cnt = dir ? 3'd0 : 3'd2;
                            end
                            `DSCD_OP_MEM, `DSCD_OP_BLOCK: begin
                                n.dat_cnt = dir ? 3'd0 : ((sz == `DSCD_SZ_LONG) ? 3'd2 : 3'd1);
                                n.ext_cnt = n.dat_cnt + ((op == `DSCD_OP_MEM) ? 3'd2 : 3'd0);
                                if (sz == `DSCD_SZ_RSVD) begin
                                    ill = 1'b1;
                                end
                                if (op == `DSCD_OP_BLOCK) begin
                                    n.blk_rd_ok = s.blk_rd_ok;
                                    n.blk_wr_ok = s.blk_wr_ok;
                                    if (dir ? !s.blk_rd_ok : !s.blk_wr_ok) begin
                                        ill = 1'b1;
                                    end
                                end
                            end
                            default: ill = 1'b1;
                        endcase
                        if (ill) begin
                            n.tx_sh = `DSCD_RSP_ILLEGAL;
                            n.status[`DSCD_EV_ILLEGAL] = 1'b1;
                            n.blk_rd_ok = s.blk_rd_ok;
                            n.blk_wr_ok = s.blk_wr_ok;
                        end else if (op == `DSCD_OP_NOP || op == `DSCD_OP_RESUME) begin
                            n.tx_sh = `DSCD_RSP_OK;
                        end else if (n.ext_cnt != 3'd0) begin
                            n.st = ST_EXT;
                        end else begin
                            go = 1'b1;
                        end
                    end
                    ST_EXT: begin
                        if (s.ext_cnt > s.dat_cnt) begin
                            n.addr = {s.addr[15:0], w};
                        end else begin
                            n.data = {s.data[15:0], w};
                        end
                        n.ext_cnt = s.ext_cnt - 3'd1;
                        go = (s.ext_cnt == 3'd1);
                    end
                    ST_DONE: begin
                        n.tx_sh = s.two ? {1'b0, s.res[31:16]} : s.fin;
                        n.st = s.two ? ST_LAST : ST_CMD;
                    end
                    ST_LAST: begin
                        n.tx_sh = {1'b0, s.res[15:0]};
                        n.st = ST_CMD;
                    end
                    default: n.st = s.st;
                endcase
            end
        end

        // Starting the operation once its last word has arrived.
        if (go) begin
            n.st = ST_BUSY;
            n.two = 1'b0;
            n.fin = `DSCD_RSP_OK;
            op = n.cmd[`DSCD_F_OP_HI:`DSCD_F_OP_LO];
            dir = n.cmd[`DSCD_F_DIR];
            sz = n.cmd[`DSCD_F_SZ_HI:`DSCD_F_SZ_LO];
            case (op)
                `DSCD_OP_MEM, `DSCD_OP_BLOCK: begin
                    a = (op == `DSCD_OP_BLOCK) ? s.blk_addr : n.addr;
                    if (sz == `DSCD_SZ_LONG) begin
                        a[1:0] = 2'b00;
                    end else if (sz == `DSCD_SZ_WORD) begin
                        a[0] = 1'b0;
                    end
                    n.addr = a;
                    n.mem_req = 1'b1;
                    n.blk_rd_ok = dir;
                    n.blk_wr_ok = !dir;
                end
                `DSCD_OP_DBG: begin
                    n.st = ST_DONE;
                    if (dir) begin
                        n.two = 1'b1;
                        n.res = 32'h0000_0000;
                        if (n.addr[3:0] == `DSCD_DBG_STATUS) begin
                            n.res[2:0] = s.status;
                        end else if (n.addr[3:0] == `DSCD_DBG_MASK) begin
                            n.res[2:0] = s.mask;
                        end
                    end else if (!halted_i) begin
                        n.fin = `DSCD_RSP_BUSERR;
                    end else if (n.addr[3:0] == `DSCD_DBG_STATUS) begin
                        // Write one to clear; events of this cycle still win.
                        n.status = (s.status & ~n.data[2:0]) | (n.status & ~s.status);
                    end else if (n.addr[3:0] == `DSCD_DBG_MASK) begin
                        n.mask = n.data[2:0];
                    end
                end
                default: begin
                    if (halted_i) begin
                        n.reg_req = 1'b1;
                    end else begin
                        n.fin = `DSCD_RSP_BUSERR;
                        n.st = ST_DONE;
                    end
                end
            endcase
        end

        // Completion of a core or bus access; the host keeps seeing not-ready.
        if (s.st == ST_BUSY) begin
            dir = s.cmd[`DSCD_F_DIR];
            sz = s.cmd[`DSCD_F_SZ_HI:`DSCD_F_SZ_LO];
            step = (sz == `DSCD_SZ_LONG) ? 32'h0000_0004 :
                   (sz == `DSCD_SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001;
            if (s.reg_req && reg_ack_i) begin
                n.reg_req = 1'b0;
                n.res = reg_rdata_i;
                n.two = dir;
                n.st = ST_DONE;
            end
            if (s.mem_req && (mem_ack_i || mem_err_i)) begin
                n.mem_req = 1'b0;
                n.blk_addr = s.addr + step;
                n.st = ST_DONE;
                if (mem_err_i) begin
                    n.fin = `DSCD_RSP_BUSERR;
                    n.status[`DSCD_EV_BUSERR] = 1'b1;
                end else if (dir) begin
                    n.res = mem_rdata_i;
                    n.two = (sz == `DSCD_SZ_LONG);
                    n.fin = {1'b0, mem_rdata_i[15:0]};
                end
            end
        end
        if (n.resume) begin
            n.status[`DSCD_EV_RESUME] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.st <= ST_CMD;
            s.tx_sh <= `DSCD_RSP_OK;
            s.fin <= `DSCD_RSP_OK;
        end else begin
            s <= n;
        end
    end

    assign link.debug_serial_out = s.tx_sh[`DSCD_PKT_BITS - 1];
    assign resume_o = s.resume;
    assign reg_req_o = s.reg_req;
    assign reg_we_o = !s.cmd[`DSCD_F_DIR];
    assign reg_space_o = (s.cmd[`DSCD_F_OP_HI:`DSCD_F_OP_LO] == `DSCD_OP_CTRL) ?
                         RS_CTRL_REG : RS_AD_REG;
    assign reg_num_o = s.addr[15:0];
    assign reg_wdata_o = s.data;
    assign mem_req_o = s.mem_req;
    assign mem_we_o = !s.cmd[`DSCD_F_DIR];
    assign mem_size_o = s.cmd[`DSCD_F_SZ_HI:`DSCD_F_SZ_LO];
    assign mem_addr_o = s.addr;
    assign mem_wdata_o = s.data;
    assign irq_o = |(s.status & s.mask);
endmodule
`default_nettype wire

// ---- rtl/dscd_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dscd_defines.svh"
module dscd_host #(
    parameter int unsigned HALF_CYC = `DSCD_SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // Serial link
    dscd_link_if.host        link,
    // Words to send
    input  wire logic [15:0] tx_word_i,
    input  wire logic        tx_valid_i,
    output logic             tx_ready_o,
    // Words received
    output logic [16:0]      rx_word_o,
    output logic             rx_valid_o
);
    import dscd_pkg::*;

    dscd_host_s s;
    dscd_host_s n;

    always_comb begin
        n = s;
        n.rx_valid = 1'b0;
        n.dout_sync = {s.dout_sync[1:0], link.debug_serial_out};
        if (s.dout_sync[2] == s.dout_sync[1]) begin
            n.dout_lvl = s.dout_sync[2];
        end
        n.div = (s.div == 8'd0) ? 8'd0 : s.div - 8'd1;
        case (s.st)
            HS_IDLE: begin
                if (tx_valid_i) begin
                    // The status bit is always sent as zero.
                    n.sh = {1'b0, tx_word_i};
                    n.din = 1'b0;
                    n.bit_cnt = 5'd0;
                    n.div = 8'(HALF_CYC - 1);
                    n.st = HS_LOW;
                end
            end
            HS_LOW: begin
                if (s.div == 8'd0) begin
                    // Sampled late in the low phase so the device output has settled.
                    n.rx = {s.rx[15:0], s.dout_lvl};
                    n.sclk = 1'b1;
                    n.div = 8'(HALF_CYC - 1);
                    n.st = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (s.div == 8'd0) begin
                    n.sclk = 1'b0;
                    if (s.bit_cnt == 5'(`DSCD_PKT_BITS - 1)) begin
                        n.rx_valid = 1'b1;
                        n.st = HS_IDLE;
                    end else begin
                        n.bit_cnt = s.bit_cnt + 5'd1;
                        n.sh = {s.sh[15:0], 1'b0};
                        n.din = s.sh[15];
                        n.div = 8'(HALF_CYC - 1);
                        n.st = HS_LOW;
                    end
                end
            end
            default: n.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.st <= HS_IDLE;
        end else begin
            s <= n;
        end
    end

    assign link.debug_serial_clk = s.sclk;
    assign link.debug_serial_in = s.din;
    assign tx_ready_o = (s.st == HS_IDLE);
    assign rx_word_o = s.rx;
    assign rx_valid_o = s.rx_valid;
endmodule
`default_nettype wire

// ---- sim/dscd_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module dscd_asserts (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Link
    input wire logic debug_serial_clk,
    input wire logic debug_serial_in,
    input wire logic debug_serial_out,
    // User sides
    input wire logic mem_req_o,
    input wire logic mem_ack_i,
    input wire logic mem_err_i,
    input wire logic reg_req_o,
    input wire logic halted_i,
    input wire logic resume_o,
    input wire logic rx_valid_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Link clock rises since the host last handed a word over.
    logic       sclk_q;
    logic [4:0] rise_q;
    logic [4:0] rise_d;

    assign rise_d = (rx_valid_o ? 5'h00 : rise_q) + {4'h0, debug_serial_clk && !sclk_q};

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q <= 1'b0;
            rise_q <= 5'h00;
        end else begin
            sclk_q <= debug_serial_clk;
            rise_q <= rise_d;
        end
    end

    sclk_high_a: assert property ($rose(debug_serial_clk) |-> debug_serial_clk [*8])
        else $error("link clock high phase too short");
    din_hold_a: assert property (debug_serial_clk && $past(debug_serial_clk)
        |-> $stable(debug_serial_in)) else $error("host data moved while clock high");
    dout_move_a: assert property ($changed(debug_serial_out) |-> debug_serial_clk)
        else $error("device data moved while clock low");
    status_bit_zero_a: assert property (debug_serial_clk && !sclk_q && rise_q == 5'h00
        |-> !debug_serial_in) else $error("host sent a set status bit");
    packet_bits_a: assert property (rx_valid_o |-> rise_q == 5'h11)
        else $error("packet length is not seventeen bits");
    mem_hold_a: assert property (mem_req_o && !mem_ack_i && !mem_err_i |=> mem_req_o)
        else $error("bus request dropped before its answer");
    mem_release_a: assert property (mem_ack_i || mem_err_i |=> !mem_req_o)
        else $error("bus request held after its answer");
    reg_halted_a: assert property ($rose(reg_req_o) |-> halted_i)
        else $error("register access while core running");
    resume_pulse_a: assert property (resume_o |=> !resume_o)
        else $error("resume pulse longer than one cycle");

    cover property (mem_req_o && mem_ack_i);
    cover property (mem_req_o && mem_err_i);
    cover property (reg_req_o && halted_i);
    cover property (resume_o);
endmodule
`default_nettype wire

// ---- sim/dscd_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dscd_defines.svh"
module dscd_tb;
    import dscd_pkg::*;
    localparam logic [17:0] OK = 18'h0_FFFF;
    localparam logic [17:0] NR = 18'h1_0000;
    localparam logic [17:0] BE = 18'h1_0001;
    localparam logic [17:0] IL = 18'h1_FFFF;
    localparam logic [5:0]  BAD [3] = '{6'h01, 6'h3F, 6'h10};
    typedef struct packed {
        logic [31:0] a;
        logic [2:0]  k;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        err;
    } dscd_bus_s;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        halted = 1'b0;
    logic [31:0] reg_rdata = 32'h0;
    logic        reg_ack = 1'b0;
    logic [31:0] mem_rdata = 32'h0;
    logic        mem_ack = 1'b0;
    logic        mem_err = 1'b0;
    logic [15:0] tx_word = 16'h0;
    logic        tx_valid = 1'b0;
    logic        resume;
    logic        reg_req;
    logic        reg_we;
    dscd_space_e reg_space;
    logic [15:0] reg_num;
    logic [31:0] reg_wdata;
    logic        mem_req;
    logic        mem_we;
    logic [1:0]  mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        irq;
    logic        tx_ready;
    logic [16:0] rx_word;
    logic        rx_valid;
    logic [31:0] seed = 32'h0000_86BC;
    logic [17:0] reg_exp = 18'h3_FFFF;
    logic [31:0] reg_val = 32'h0;
    logic [31:0] reg_wd = 32'h0;
    int          err_count = 0;
    int          checked = 0;
    int          resumes = 0;
    logic [17:0] exp_q[$];
    dscd_bus_s   bus_q[$];

    dscd_link_if link ();
    dscd_device u_dscd_device (
        .ref_clk_i(clk), .resetn_i(resetn), .link(link.dev), .halted_i(halted),
        .resume_o(resume), .reg_req_o(reg_req), .reg_we_o(reg_we), .reg_space_o(reg_space),
        .reg_num_o(reg_num), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
        .reg_ack_i(reg_ack), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_size_o(mem_size),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
        .mem_ack_i(mem_ack), .mem_err_i(mem_err), .irq_o(irq));
    dscd_host u_dscd_host (
        .ref_clk_i(clk), .resetn_i(resetn), .link(link.host), .tx_word_i(tx_word),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid));
    dscd_asserts u_dscd_asserts (
        .ref_clk_i(clk), .resetn_i(resetn), .debug_serial_clk(link.debug_serial_clk),
        .debug_serial_in(link.debug_serial_in), .debug_serial_out(link.debug_serial_out),
        .mem_req_o(mem_req), .mem_ack_i(mem_ack), .mem_err_i(mem_err), .reg_req_o(reg_req),
        .halted_i(halted), .resume_o(resume), .rx_valid_o(rx_valid));

    always #50 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [15:0] cw(input logic [5:0] op, input logic d,
                                       input logic [1:0] s, input logic [3:0] r);
        return {op, 1'b0, d, s, 2'b00, r};
    endfunction

    task automatic finish_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_rsp(input logic [17:0] e, input logic [16:0] g);
        checked++;
        if (!e[17] && g !== e[16:0]) begin
            err_count++;
            $display("ERROR response expected %h seen %h", e[16:0], g);
        end
    endtask

    // Sends one word and notes the response expected in that same packet.
    task automatic send(input logic [15:0] w, input logic [17:0] e);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            err_count++;
            finish_test();
        end
        exp_q.push_back(e);
        tx_word <= w;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    // Command, address, data, one busy packet, then results; the last packet carries a no-op.
    task automatic xfer(input logic [15:0] c, input logic ha, input logic [31:0] a,
                        input int nd, input logic [31:0] wd, input logic [17:0] xr,
                        input int nr, input logic [31:0] rv, input logic [17:0] rs);
        send(c, OK);
        if (ha) begin
            send(a[31:16], NR);
            send(a[15:0], NR);
        end
        if (nd == 2) send(wd[31:16], NR);
        if (nd > 0) send(wd[15:0], NR);
        send(16'h0, xr);
        if (nr == 2) send(16'h0, {2'b00, rv[31:16]});
        send(16'h0, (nr > 0) ? {2'b00, rv[15:0]} : rs);
    endtask

    task automatic dbg_wr(input logic [3:0] r, input logic [31:0] v);
        xfer(cw(`DSCD_OP_DBG, 1'b0, `DSCD_SZ_LONG, r), 1'b0, 32'h0, 2, v, NR, 0, 32'h0, OK);
    endtask

    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp_val("response count", 32'h0, 32'h1);
            else cmp_rsp(exp_q.pop_front(), rx_word);
        end
    end

    // Memory and core sides answer after a random number of cycles.
    always @(posedge clk) begin
        dscd_bus_s b;
        seed <= xs(seed);
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        reg_ack <= 1'b0;
        if (mem_req === 1'b1 && !mem_ack && !mem_err && seed[0]) begin
            // An unexpected request meets an impossible note and is reported.
            b = (bus_q.size() > 0) ? bus_q.pop_front() : '1;
            cmp_val("bus address", b.a, mem_addr);
            cmp_val("bus kind", {29'h0, b.k}, {29'h0, mem_we, mem_size});
            if (b.k[2]) cmp_val("bus data", b.wd, mem_wdata & ((b.k[1:0] == 2'h2) ?
                32'hFFFF_FFFF : (b.k[0] ? 32'h0000_FFFF : 32'h0000_00FF)));
            mem_rdata <= b.rd;
            mem_err <= b.err;
            mem_ack <= !b.err;
        end
        if (reg_req === 1'b1 && !reg_ack && seed[1]) begin
            cmp_val("reg select", {14'h0, reg_exp}, {14'h0, reg_we, reg_space, reg_num});
            if (reg_we) cmp_val("reg data", reg_wd, reg_wdata);
            reg_rdata <= reg_val;
            reg_ack <= 1'b1;
        end
        if (resume === 1'b1) resumes++;
    end

    initial begin
        logic [31:0] a;
        logic [31:0] d;
        int          n;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        cmp_val("irq after reset", 32'h0, {31'h0, irq});
        halted <= 1'b1;
        dbg_wr(`DSCD_DBG_MASK, 32'h0000_0007);
        cmp_val("irq idle", 32'h0, {31'h0, irq});
        foreach (BAD[i]) begin
            send(cw(BAD[i], 1'b1, `DSCD_SZ_WORD, 4'h0), OK);
            send(16'h0, IL);
        end
        send(cw(`DSCD_OP_MEM, 1'b1, `DSCD_SZ_RSVD, 4'h0), OK);
        send(16'h0, IL);
        cmp_val("irq on illegal", 32'h1, {31'h0, irq});
        dbg_wr(`DSCD_DBG_STATUS, 32'h0000_0007);
        cmp_val("irq cleared", 32'h0, {31'h0, irq});
        halted <= 1'b0;
        a = seed;
        d = xs(seed);
        bus_q.push_back({a & 32'hFFFF_FFFC, 1'b0, `DSCD_SZ_LONG, 32'h0, d, 1'b0});
        xfer(cw(`DSCD_OP_MEM, 1'b1, `DSCD_SZ_LONG, 4'h0), 1'b1, a, 0, 0, NR, 2, d, OK);
        a = (a & 32'hFFFF_FFFC) + 32'h0000_0004;
        bus_q.push_back({a, 1'b0, `DSCD_SZ_WORD, 32'h0, ~d, 1'b0});
        xfer(cw(`DSCD_OP_BLOCK, 1'b1, `DSCD_SZ_WORD, 4'h0), 1'b0, 0, 0, 0, NR, 1, ~d, OK);
        bus_q.push_back({a + 32'h0000_0002, 1'b0, `DSCD_SZ_BYTE, 32'h0, d, 1'b0});
        xfer(cw(`DSCD_OP_BLOCK, 1'b1, `DSCD_SZ_BYTE, 4'h0), 1'b0, 0, 0, 0, NR, 1, d, OK);
        a = xs(d) & 32'hFFFF_FFFE;
        bus_q.push_back({a, 1'b1, `DSCD_SZ_BYTE, {24'h0, d[7:0]}, 32'h0, 1'b0});
        xfer(cw(`DSCD_OP_MEM, 1'b0, `DSCD_SZ_BYTE, 4'h0), 1'b1, a, 1, {24'h0, d[7:0]},
             NR, 0, 0, OK);
        bus_q.push_back({a, 1'b1, `DSCD_SZ_WORD, {16'h0, d[31:16]}, 32'h0, 1'b0});
        xfer(cw(`DSCD_OP_BLOCK, 1'b0, `DSCD_SZ_WORD, 4'h0), 1'b0, 0, 1, {16'h0, d[31:16]},
             NR, 0, 0, OK);
        bus_q.push_back({a, 1'b0, `DSCD_SZ_WORD, 32'h0, d, 1'b1});
        xfer(cw(`DSCD_OP_MEM, 1'b1, `DSCD_SZ_WORD, 4'h0), 1'b1, a, 0, 0, NR, 0, 0, BE);
        cmp_val("irq on bus error", 32'h1, {31'h0, irq});
        xfer(cw(`DSCD_OP_DBG, 1'b1, `DSCD_SZ_LONG, 4'h0), 1'b0, 0, 0, 0, NR, 2, 32'h0000_0002,
             OK);
        xfer(cw(`DSCD_OP_ADREG, 1'b0, `DSCD_SZ_LONG, 4'h2), 1'b0, 0, 2, d, NR, 0, 0, BE);
        halted <= 1'b1;
        dbg_wr(`DSCD_DBG_STATUS, 32'h0000_0007);
        cmp_val("irq cleared", 32'h0, {31'h0, irq});
        reg_exp = {1'b0, RS_AD_REG, 16'h000D};
        reg_val = xs(d);
        xfer(cw(`DSCD_OP_ADREG, 1'b1, `DSCD_SZ_LONG, 4'hD), 1'b0, 0, 0, 0, NR, 2, reg_val,
             OK);
        reg_exp = {1'b1, RS_AD_REG, 16'h0002};
        reg_wd = d;
        xfer(cw(`DSCD_OP_ADREG, 1'b0, `DSCD_SZ_LONG, 4'h2), 1'b0, 0, 2, d, NR, 0, 0, OK);
        reg_exp = {1'b1, RS_CTRL_REG, a[15:0]};
        xfer(cw(`DSCD_OP_CTRL, 1'b0, `DSCD_SZ_LONG, 4'h0), 1'b1, a, 2, d, NR, 0, 0, OK);
        n = resumes;
        send(cw(`DSCD_OP_RESUME, 1'b0, 2'h0, 4'h0), OK);
        send(16'h0, OK);
        cmp_val("resume pulses", n + 1, resumes);
        n = 0;
        while (exp_q.size() > 0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
